/* rate_gen_map.svh */
// offsets, field positions and reset values of the rate generator
`ifndef RATE_GEN_MAP_SVH
`define RATE_GEN_MAP_SVH
`define ADDR_DIV_LOW 3'h0
`define ADDR_DIV_HIGH 3'h1
`define ADDR_DIV_FRAC 3'h2
`define ADDR_MODEM_CTRL 3'h4
`define DIV_LOW_RESET 8'h01
`define DIV_HIGH_RESET 8'h00
`define DIV_FRAC_RESET 8'h00
`define MODEM_CTRL_RESET 8'h00
`define PRESCALE_BIT 7
`define FRAC_LSB 0
`define FRAC_MSB 3
`define MODE_LSB 4
`define MODE_MSB 5
`define FRAC_IMPL_MASK 8'h3f
`define PRESCALE_DIV4_COUNT 2'h3
`define DEVICE_ID_CODE 8'h5a
`define REVISION_CODE 8'h01
`endif

/* rate_gen_pkg.sv */
// types of the rate generator
package rate_gen_pkg;
  typedef enum logic [1:0] {
    sample_16x,
    sample_8x,
    sample_4x,
    sample_rsvd
  } sample_mode_e;
  typedef logic [15:0] divisor_t;
endpackage

/* rate_divider.sv */
// one channel's prescaler, fractional divider and per-bit enable
`timescale 1ns/1ns
`include "rate_gen_map.svh"
module rate_divider
  import rate_gen_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // settings
  input wire logic prescale_div4,
  input wire divisor_t int_divisor,
  input wire logic [3:0] frac_divisor,
  input wire sample_mode_e sample_mode,
  // outputs
  output logic sample_tick,
  output logic bit_tick
);
  logic [1:0] pre_cnt_q;
  logic pre_en;
  logic [15:0] div_cnt_q;
  logic [3:0] frac_acc_q;
  logic stretch_q;
  logic [3:0] bit_cnt_q;
  logic [3:0] bit_last;
  logic carry;
  logic [4:0] acc_sum;

  // prescaler divides by 4 when set, otherwise passes every cycle
  assign pre_en = !prescale_div4 || (pre_cnt_q == `PRESCALE_DIV4_COUNT);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt_q <= 2'h0;
    end else if (!prescale_div4) begin
      pre_cnt_q <= 2'h0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 2'h1;
    end
  end

  // accumulator carry stretches frac of every 16 ticks by one period
  assign acc_sum = {1'b0, frac_acc_q} + {1'b0, frac_divisor};
  assign carry = acc_sum[4];

  // integer divisor zero behaves as one would; id reads need zero anyway
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_q <= 16'h0;
      frac_acc_q <= 4'h0;
      stretch_q <= 1'b0;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= 1'b0;
      if (pre_en) begin
        if (div_cnt_q + 16'h1 < int_divisor) begin
          div_cnt_q <= div_cnt_q + 16'h1;
        end else if (stretch_q) begin
          stretch_q <= 1'b0;
        end else begin
          div_cnt_q <= 16'h0;
          frac_acc_q <= acc_sum[3:0];
          stretch_q <= carry;
          sample_tick <= 1'b1;
        end
      end
    end
  end

  // ticks per bit from the sampling mode; 8x with odd fraction jitters
  assign bit_last = (sample_mode == sample_8x) ? 4'h7 :
                    (sample_mode == sample_4x) ? 4'h3 : 4'hf;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_q <= 4'h0;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= 1'b0;
      if (sample_tick) begin
        if (bit_cnt_q >= bit_last) begin
          bit_cnt_q <= 4'h0;
          bit_tick <= 1'b1;
        end else begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
      end
    end
  end
endmodule

/* rate_generator.sv */
// dual channel fractional rate generator with its divisor registers
// How it works
// - each channel owns prescaler and rate generator
// - modem control bit 7 selects divide-by-4
// - divisor 1 to 65536-1/16, sixteenth steps
// - reset divisor is one: 01,00,00
// - low and high bytes form integer part
// - low four fraction bits give sixteenths
// - bits 5:4 select 16x, 8x, 4x
// - sampling tick drives transmit and receive
// - 8x odd fraction jitter is acceptable
// - register access needs no oscillator clock; here the registers run on core_clk
// - zero divisor reads give id, revision
`timescale 1ns/1ns
`include "rate_gen_map.svh"
module rate_generator
  import rate_gen_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // host register port, one cycle strobes
  input wire logic channel_sel,
  input wire logic [2:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // per channel sampling and bit ticks, index 0 is channel b
  output logic [1:0] tx_sample_tick,
  output logic [1:0] rx_sample_tick,
  output logic [1:0] bit_tick
);
  logic [7:0] div_low_q [2];
  logic [7:0] div_high_q [2];
  logic [7:0] div_frac_q [2];
  logic [7:0] modem_ctrl_q [2];
  logic [1:0] sample_tick;
  logic [1:0] bit_tick_int;
  logic [7:0] rdata_d;
  logic ch;

  assign ch = channel_sel;

  // both divisor bytes zero swaps in the identification codes
  function automatic logic divisor_is_zero(input logic [7:0] lo, input logic [7:0] hi);
    return (lo == 8'h00) && (hi == 8'h00);
  endfunction

  // registers kept on core_clk here; the real part latches them on the
  // host strobes so that access needs no oscillator clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 2; i++) begin
        div_low_q[i] <= `DIV_LOW_RESET;
        div_high_q[i] <= `DIV_HIGH_RESET;
        div_frac_q[i] <= `DIV_FRAC_RESET;
        modem_ctrl_q[i] <= `MODEM_CTRL_RESET;
      end
    end else if (reg_write) begin
      if (reg_addr == `ADDR_DIV_LOW) begin
        div_low_q[ch] <= reg_wdata;
      end else if (reg_addr == `ADDR_DIV_HIGH) begin
        div_high_q[ch] <= reg_wdata;
      end else if (reg_addr == `ADDR_DIV_FRAC) begin
        div_frac_q[ch] <= reg_wdata & `FRAC_IMPL_MASK;
      end else if (reg_addr == `ADDR_MODEM_CTRL) begin
        modem_ctrl_q[ch] <= reg_wdata;
      end
    end
  end

  // read mux; zero divisor swaps in identification codes
  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr == `ADDR_DIV_LOW) begin
      rdata_d = div_low_q[ch];
      if (divisor_is_zero(div_low_q[ch], div_high_q[ch])) begin
        rdata_d = `REVISION_CODE;
      end
    end else if (reg_addr == `ADDR_DIV_HIGH) begin
      rdata_d = div_high_q[ch];
      if (divisor_is_zero(div_low_q[ch], div_high_q[ch])) begin
        rdata_d = `DEVICE_ID_CODE;
      end
    end else if (reg_addr == `ADDR_DIV_FRAC) begin
      rdata_d = div_frac_q[ch];
    end else if (reg_addr == `ADDR_MODEM_CTRL) begin
      rdata_d = modem_ctrl_q[ch];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= rdata_d;
    end
  end

  // one independent generator per channel
  for (genvar g = 0; g < 2; g++) begin : gen_chan
    rate_divider u_div (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .prescale_div4(modem_ctrl_q[g][`PRESCALE_BIT]),
      .int_divisor({div_high_q[g], div_low_q[g]}),
      .frac_divisor(div_frac_q[g][`FRAC_MSB:`FRAC_LSB]),
      .sample_mode(sample_mode_e'(div_frac_q[g][`MODE_MSB:`MODE_LSB])),
      .sample_tick(sample_tick[g]),
      .bit_tick(bit_tick_int[g])
    );
  end

  // same tick feeds both directions of a channel, registered for timing
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_sample_tick <= 2'h0;
      rx_sample_tick <= 2'h0;
      bit_tick <= 2'h0;
    end else begin
      tx_sample_tick <= sample_tick;
      rx_sample_tick <= sample_tick;
      bit_tick <= bit_tick_int;
    end
  end
endmodule

/* rate_generator_sva.sv */
// port assertions for the rate generator
`timescale 1ns/1ns
module rate_generator_sva (
  // clock and reset
  input wire logic core_clk, reset_n,
  // host port
  input wire logic channel_sel, reg_write, reg_read,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata,
  // ticks
  input wire logic [1:0] tx_sample_tick, rx_sample_tick, bit_tick
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_tx_rx_same: assert property (tx_sample_tick == rx_sample_tick)
    else $error("tx and rx ticks differ");
  a_frac_masked: assert property (reg_write && reg_addr == 3'h2 ##1 reg_read &&
    reg_addr == 3'h2 && $stable(channel_sel) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3f))
    else $error("fraction readback wrong");
  a_low_readback: assert property (reg_write && reg_addr == 3'h0 && reg_wdata != 8'h00
    ##1 reg_read && reg_addr == 3'h0 && $stable(channel_sel) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("low byte readback wrong");
  a_high_readback: assert property (reg_write && reg_addr == 3'h1 && reg_wdata != 8'h00
    ##1 reg_read && reg_addr == 3'h1 && $stable(channel_sel) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("high byte readback wrong");
  a_unmapped_zero: assert property (reg_read && reg_addr inside {3'h3, [3'h5:3'h7]}
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  // read data must not drift between reads
  a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata)) else $error("rdata moved");
  // shortest bit is four ticks of one cycle
  a_bit_gap_b: assert property (bit_tick[0] |=> !bit_tick[0] [*3])
    else $error("channel b bit too short");
  a_bit_gap_a: assert property (bit_tick[1] |=> !bit_tick[1] [*3])
    else $error("channel a bit too short");
endmodule
bind rate_generator rate_generator_sva u_rate_generator_sva (.*);

/* rate_generator_tb.sv */
// self-checking bench for the rate generator
`timescale 1ns/1ns
`include "rate_gen_map.svh"
module rate_generator_tb;
  logic core_clk = 1'b0, reset_n = 1'b0, channel_sel = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [1:0] tx_sample_tick, rx_sample_tick, bit_tick;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  rate_generator u_rate_generator (.*);
  initial forever #5 core_clk = ~core_clk;
  task results;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task cmp(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  // strobes stay up so calls can run back to back
  task wr(logic c, logic [2:0] a, logic [7:0] d);
    channel_sel = c; reg_addr = a; reg_wdata = d; reg_read = 1'b0; reg_write = 1'b1;
    @(posedge core_clk) #1;
  endtask
  task rd(logic c, logic [2:0] a, logic [7:0] e);
    channel_sel = c; reg_addr = a; reg_write = 1'b0; reg_read = 1'b1;
    @(posedge core_clk) #1 cmp("rdata", e, reg_rdata);
  endtask
  // skips two ticks so a reprogram settles, then times n ticks
  task per(logic c, logic b, int n, int e);
    int k, t;
    reg_write = 1'b0; reg_read = 1'b0; k = 0; t = 0;
    while (k < n + 2) begin
      @(posedge core_clk) #1;
      if (k > 1) t++;
      if ((b ? bit_tick[c] : tx_sample_tick[c]) === 1'b1) k++;
    end
    cmp("period", e, t);
  endtask
  always @(posedge core_clk) if (++cyc == 20000) begin num_errors++; results; end
  initial begin
    repeat (4) @(posedge core_clk);
    #1 reset_n = 1'b1;
    for (int c = 0; c < 2; c++) begin
      rd(c, 3'h0, 8'h01);
      rd(c, 3'h1, 8'h00);
      rd(c, 3'h2, 8'h00);
    end
    per(1'b1, 1'b0, 16, 16);
    $display("test reset done");
    wr(1'b1, 3'h0, 8'h03);
    wr(1'b1, 3'h2, 8'hff);
    rd(1'b1, 3'h2, 8'h3f);
    wr(1'b1, 3'h2, 8'h04);
    per(1'b1, 1'b0, 16, 52);
    per(1'b0, 1'b0, 16, 16);
    for (int m = 0; m < 3; m++) begin
      wr(1'b1, 3'h2, {2'h0, m[1:0], 4'h0});
      per(1'b1, 1'b1, 2, (16 >> m) * 6);
    end
    wr(1'b1, 3'h4, 8'h80);
    per(1'b1, 1'b0, 4, 48);
    $display("test rate done");
    wr(1'b1, 3'h1, 8'h12);
    rd(1'b1, 3'h1, 8'h12);
    wr(1'b1, 3'h3, 8'haa);
    rd(1'b1, 3'h3, 8'h00);
    wr(1'b0, 3'h0, 8'h00);
    rd(1'b0, 3'h1, `DEVICE_ID_CODE);
    rd(1'b0, 3'h0, `REVISION_CODE);
    $display("test regs done");
    results;
  end
endmodule
